/* rtl/pbs_port.sv */
`include "pbs_cfg.svh"

module pbs_port
  import pbs_pkg::*;
(
  input  wire logic                   CORE_CLK_I,
  input  wire logic                   SYS_RST_I,
  input  wire logic [`PBS_ADDR_W-1:0] ADDR_I,
  input  wire logic                   MASTER_CHIP_SELECT_N_I,
  input  wire logic                   CHIP_SELECT_HIGH_I,
  input  wire logic                   CHIP_SELECT_LOW_N_I,
  input  wire logic                   PROC_ADDR_STROBE_N_I,
  input  wire logic                   CTRL_ADDR_STROBE_N_I,
  input  wire logic                   BURST_STEP_N_I,
  input  wire logic                   GLOBAL_WRITE_N_I,
  input  wire logic                   BYTE_WRITE_GATE_N_I,
  input  wire logic [`PBS_LANES-1:0]  BYTE_LANE_WRITE_N_I,
  input  wire logic                   OUT_ENABLE_N_I,
  input  wire logic                   BURST_ORDER_SELECT_I,
  input  wire logic                   SNOOZE_PIN_I,
  input  wire logic [`PBS_DATA_W-1:0] DQ_I,
  output logic      [`PBS_DATA_W-1:0] DQ_O,
  output logic                        DQ_OE_N_O,
  output logic                        SNOOZE_ACTIVE_O
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [`PBS_SYNC_W-1:0] sync_meta_reg;
  logic [`PBS_SYNC_W-1:0] sync_reg;
  logic                   oe_n_s;
  logic                   snooze_s;
  logic                   order_s;

  pbs_op_t                op_reg;
  pbs_op_t                op_next;
  pbs_acc_t               acc_reg;
  logic [`PBS_ADDR_W-1:0] base_reg;
  logic [`PBS_LOW_W-1:0]  cnt_reg;
  logic [`PBS_LOW_W-1:0]  cnt_inc;
  logic [`PBS_LOW_W-1:0]  low_next;
  logic                   dq_oe_n_reg;

  logic                   sel_all;
  logic                   proc_take;
  logic                   ctrl_take;
  logic                   both_high;
  logic                   burst_live;
  logic                   adv_go;
  logic                   load_go;
  logic [`PBS_LANES-1:0]  lane_we;

  //////////////////////////////////////////////////////////////////////////////
  // two-flop capture of the unclocked pins

  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      sync_meta_reg <= `PBS_SYNC_RST;
      sync_reg      <= `PBS_SYNC_RST;
    end else begin
      sync_meta_reg <= {BURST_ORDER_SELECT_I, SNOOZE_PIN_I, OUT_ENABLE_N_I};
      sync_reg      <= sync_meta_reg;
    end
  end

  assign oe_n_s   = sync_reg[`PBS_SYNC_OE];
  assign snooze_s = sync_reg[`PBS_SYNC_SNZ];
  assign order_s  = sync_reg[`PBS_SYNC_ORD];

  //////////////////////////////////////////////////////////////////////////////
  // strobe and select qualification

  assign sel_all    = !MASTER_CHIP_SELECT_N_I && CHIP_SELECT_HIGH_I && !CHIP_SELECT_LOW_N_I;
  assign proc_take  = !PROC_ADDR_STROBE_N_I && !MASTER_CHIP_SELECT_N_I;
  assign ctrl_take  = !CTRL_ADDR_STROBE_N_I && !proc_take;
  assign both_high  = !proc_take && CTRL_ADDR_STROBE_N_I;
  assign burst_live = (op_reg != PBS_DESEL);
  assign load_go    = !snooze_s && (proc_take || ctrl_take) && sel_all;
  assign adv_go     = !snooze_s && both_high && burst_live && !BURST_STEP_N_I;

  // write decode per lane
  always_comb begin
    lane_we = `PBS_NO_LANES;
    if (!GLOBAL_WRITE_N_I) begin
      lane_we = `PBS_ALL_LANES;
    end else if (!BYTE_WRITE_GATE_N_I) begin
      lane_we = ~BYTE_LANE_WRITE_N_I;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // burst address sequencing

  assign cnt_inc = cnt_reg + `PBS_CNT_ONE;

  always_comb begin
    if (order_s) begin
      low_next = base_reg[`PBS_LOW_W-1:0] ^ cnt_inc;
    end else begin
      low_next = base_reg[`PBS_LOW_W-1:0] + cnt_inc;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      base_reg <= `PBS_ADDR_RST;
      cnt_reg  <= `PBS_CNT_ZERO;
    end else if (load_go) begin
      base_reg <= ADDR_I;
      cnt_reg  <= `PBS_CNT_ZERO;
    end else if (adv_go) begin
      cnt_reg  <= cnt_inc;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // operation decision

  always_comb begin
    op_next = PBS_DESEL;
    if (snooze_s) begin
      op_next = PBS_DESEL;
    end else if (proc_take) begin
      op_next = sel_all ? PBS_READ : PBS_DESEL;
    end else if (ctrl_take) begin
      if (!sel_all) begin
        op_next = PBS_DESEL;
      end else begin
        op_next = (|lane_we) ? PBS_WRITE : PBS_READ;
      end
    end else if (burst_live) begin
      op_next = (|lane_we) ? PBS_WRITE : PBS_READ;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      op_reg <= PBS_DESEL;
    end else begin
      op_reg <= op_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // access handed to the array on the next edge

  // one process owns the whole access word, so the packed struct has a single driver
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      acc_reg.addr  <= `PBS_ADDR_RST;
      acc_reg.be    <= `PBS_NO_LANES;
      acc_reg.wdata <= `PBS_DATA_RST;
    end else begin
      if (load_go) begin
        acc_reg.addr <= ADDR_I;
      end else if (adv_go) begin
        acc_reg.addr <= {base_reg[`PBS_ADDR_W-1:`PBS_LOW_W], low_next};
      end
      acc_reg.be    <= (op_next == PBS_WRITE) ? lane_we : `PBS_NO_LANES;
      acc_reg.wdata <= DQ_I;
    end
  end

  pbs_mem u_pbs_mem (
    .clk_i   (CORE_CLK_I),
    .acc_i   (acc_reg),
    .rdata_o (DQ_O)
  );

  //////////////////////////////////////////////////////////////////////////////
  // output driver enable, aligned with the read data register

  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      dq_oe_n_reg <= 1'b1;
    end else begin
      dq_oe_n_reg <= !((op_reg == PBS_READ) && !oe_n_s && !snooze_s);
    end
  end

  assign DQ_OE_N_O       = dq_oe_n_reg;
  assign SNOOZE_ACTIVE_O = snooze_s;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  a_addr_capture: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (!snooze_s && proc_take && sel_all) |=> (op_reg == PBS_READ && acc_reg.addr == $past(ADDR_I))
  ) else $error("address not captured on selected strobe");

  a_master_blocks: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (MASTER_CHIP_SELECT_N_I && !CTRL_ADDR_STROBE_N_I) |=> (op_reg == PBS_DESEL)
  ) else $error("controller strobe with master select off did not deselect");

  a_drive_cause: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    !dq_oe_n_reg |-> ($past(op_reg) == PBS_READ && !$past(oe_n_s) && !$past(snooze_s))
  ) else $error("data driven outside a read with output enable");

  a_global_write: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (!snooze_s && ctrl_take && sel_all && !GLOBAL_WRITE_N_I) |=> (acc_reg.be == `PBS_ALL_LANES)
  ) else $error("global write did not enable both lanes");

  a_step_hold: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (!snooze_s && both_high && burst_live && BURST_STEP_N_I) |=> $stable(acc_reg.addr)
  ) else $error("address moved without burst step");

  a_interleave_seq: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (adv_go && order_s) |=>
      (acc_reg.addr[`PBS_LOW_W-1:0] == ($past(base_reg[`PBS_LOW_W-1:0]) ^ $past(cnt_inc)))
  ) else $error("interleaved burst address wrong");

  a_linear_seq: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (adv_go && !order_s) |=>
      (acc_reg.addr[`PBS_LOW_W-1:0] == $past(base_reg[`PBS_LOW_W-1:0]) + $past(cnt_inc))
  ) else $error("linear burst address wrong");

  a_upper_fixed: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    adv_go |=> (acc_reg.addr[`PBS_ADDR_W-1:`PBS_LOW_W] == $past(base_reg[`PBS_ADDR_W-1:`PBS_LOW_W]))
  ) else $error("burst left its group of four");

  a_snooze_quiet: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    snooze_s[*2] |-> (op_reg == PBS_DESEL && dq_oe_n_reg && acc_reg.be == `PBS_NO_LANES)
  ) else $error("activity while in snooze");

  a_read_pipe: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (op_reg == PBS_READ && !oe_n_s && !snooze_s) |=> !dq_oe_n_reg
  ) else $error("read data not presented on the following edge");

  a_proc_ignores_lanes: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (!snooze_s && proc_take) |=> (acc_reg.be == `PBS_NO_LANES)
  ) else $error("lane enables acted on processor strobe edge");

  a_lane_write: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (!snooze_s && ctrl_take && sel_all && GLOBAL_WRITE_N_I && !BYTE_WRITE_GATE_N_I &&
     (BYTE_LANE_WRITE_N_I != `PBS_ALL_LANES)) |=> (op_reg == PBS_WRITE)
  ) else $error("lane enable low did not start a write");

  a_lane_select: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (!snooze_s && ctrl_take && sel_all && GLOBAL_WRITE_N_I && !BYTE_WRITE_GATE_N_I)
      |=> (acc_reg.be == ~$past(BYTE_LANE_WRITE_N_I))
  ) else $error("written lanes differ from lane enables");

  a_gate_read: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (!snooze_s && ctrl_take && sel_all && GLOBAL_WRITE_N_I && BYTE_WRITE_GATE_N_I) |=> (op_reg == PBS_READ)
  ) else $error("byte write gate high did not read");

  a_select_decode: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (!snooze_s && (proc_take || !CTRL_ADDR_STROBE_N_I) && (!CHIP_SELECT_HIGH_I || CHIP_SELECT_LOW_N_I)) |=> (op_reg == PBS_DESEL)
  ) else $error("inactive secondary select did not deselect");

  a_strobe_load: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    load_go |=> (base_reg == $past(ADDR_I) && cnt_reg == `PBS_CNT_ZERO)
  ) else $error("strobe did not load a new address");

  a_burst_wrap: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (adv_go && cnt_inc == `PBS_CNT_ZERO) |=> (acc_reg.addr == $past(base_reg))
  ) else $error("burst did not wrap to its start");

  a_snooze_sync: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (!$past(SYS_RST_I) && !$past(SYS_RST_I, 2)) |-> (snooze_s == $past(SNOOZE_PIN_I, 2))
  ) else $error("snooze state does not follow its pin");

  a_write_float: assert property (
    @(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    (op_reg == PBS_WRITE) |=> dq_oe_n_reg
  ) else $error("data driven during a write");

endmodule : pbs_port

/* rtl/pbs_cfg.svh */
`ifndef PBS_CFG_SVH
`define PBS_CFG_SVH

`define PBS_ADDR_W     19
`define PBS_DATA_W     18
`define PBS_LANES      2
`define PBS_LANE_W     9
`define PBS_DEPTH      524288
`define PBS_LOW_W      2
`define PBS_ALL_LANES  2'h3
`define PBS_NO_LANES   2'h0
`define PBS_CNT_ZERO   2'h0
`define PBS_CNT_ONE    2'h1
`define PBS_SYNC_W     3
`define PBS_SYNC_RST   3'h5
`define PBS_SYNC_OE    0
`define PBS_SYNC_SNZ   1
`define PBS_SYNC_ORD   2
`define PBS_ADDR_RST   19'h00000
`define PBS_DATA_RST   18'h00000

`endif

/* rtl/pbs_pkg.sv */
`include "pbs_cfg.svh"

package pbs_pkg;

  typedef enum logic [1:0] {
    PBS_DESEL = 2'h0,
    PBS_READ  = 2'h1,
    PBS_WRITE = 2'h2
  } pbs_op_t;

  // one access as it is handed to the array on the following edge
  typedef struct packed {
    logic [`PBS_ADDR_W-1:0] addr;
    logic [`PBS_LANES-1:0]  be;
    logic [`PBS_DATA_W-1:0] wdata;
  } pbs_acc_t;

endpackage : pbs_pkg

/* rtl/pbs_mem.sv */
`include "pbs_cfg.svh"

module pbs_mem
  import pbs_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire pbs_acc_t               acc_i,
  output logic [`PBS_DATA_W-1:0]      rdata_o
);

  logic [`PBS_DATA_W-1:0] mem_array [`PBS_DEPTH];

  // contents are never cleared, so they survive snooze and reset
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < `PBS_LANES; i++) begin
      if (acc_i.be[i]) begin
        mem_array[acc_i.addr][i*`PBS_LANE_W +: `PBS_LANE_W] <= acc_i.wdata[i*`PBS_LANE_W +: `PBS_LANE_W];
      end
    end
  end

  // read data always leaves through a register
  always_ff @(posedge clk_i) begin
    rdata_o <= mem_array[acc_i.addr];
  end

endmodule : pbs_mem

/* bench/pbs_host.sv */
`include "pbs_cfg.svh"
module pbs_host
  import pbs_pkg::*;
(
  input  wire logic  clk_i,
  output logic [18:0] a_o,
  output logic [2:0]  cs_o,
  output logic        pas_n_o,
  output logic        cas_n_o,
  output logic        step_n_o,
  output logic        gw_n_o,
  output logic        gate_n_o,
  output logic [1:0]  lane_n_o,
  output logic        oe_n_o,
  output logic        ord_o,
  output logic        snz_o,
  output logic [17:0] d_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {a_o, d_o} = '0;
    cs_o = 3'h2;
    {pas_n_o, cas_n_o, step_n_o, gw_n_o, gate_n_o, lane_n_o, oe_n_o, ord_o} = '1;
    snz_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask : tick
  // released address and data flip so a stale value never matches
  task automatic idle();
    {pas_n_o, cas_n_o, step_n_o, gw_n_o, gate_n_o, lane_n_o} = '1;
    a_o = ~a_o;
    d_o = ~d_o;
    tick();
  endtask : idle
  task automatic load(input logic [18:0] a, input logic [2:0] cs, input logic proc,
                      input logic [3:0] wr, input logic [17:0] d);
    a_o = a;
    cs_o = cs;
    pas_n_o = ~proc;
    cas_n_o = proc;
    step_n_o = 1'b0;
    {gw_n_o, gate_n_o, lane_n_o} = wr;
    d_o = d;
    tick();
  endtask : load
  task automatic step(input logic go_n, input logic gw_n, input logic [17:0] d);
    {pas_n_o, cas_n_o, gate_n_o, lane_n_o} = '1;
    a_o = ~a_o;
    step_n_o = go_n;
    gw_n_o = gw_n;
    d_o = d;
    tick();
  endtask : step
  // no access may be in flight when the power-down pin moves
  task automatic snooze(input logic on);
    idle();
    snz_o = on;
    repeat (3) idle();
  endtask : snooze
  task automatic pins(input logic oe_n, input logic ord);
    oe_n_o = oe_n;
    ord_o = ord;
    repeat (4) idle();
  endtask : pins
endmodule : pbs_host

/* bench/testbench.sv */
`include "pbs_cfg.svh"
module testbench
  import pbs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [18:0] BASE = 19'h12344;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [18:0] a;
  logic [17:0] d, dq;
  logic [17:0] grp [4];
  logic [2:0] cs;
  logic [1:0] lane_n;
  logic pas_n, cas_n, step_n, gw_n, gate_n, oe_n, ord, snz, dq_oe_n, snz_act;
  int fail_count = 0;
  int checked = 0;
  always #4 clk = ~clk;
  pbs_host u_pbs_host (.clk_i(clk), .a_o(a), .cs_o(cs), .pas_n_o(pas_n), .cas_n_o(cas_n), .step_n_o(step_n),
    .gw_n_o(gw_n), .gate_n_o(gate_n), .lane_n_o(lane_n), .oe_n_o(oe_n), .ord_o(ord), .snz_o(snz), .d_o(d));
  pbs_port u_pbs_port (.CORE_CLK_I(clk), .SYS_RST_I(rst), .ADDR_I(a), .MASTER_CHIP_SELECT_N_I(cs[2]),
    .CHIP_SELECT_HIGH_I(cs[1]), .CHIP_SELECT_LOW_N_I(cs[0]), .PROC_ADDR_STROBE_N_I(pas_n),
    .CTRL_ADDR_STROBE_N_I(cas_n), .BURST_STEP_N_I(step_n), .GLOBAL_WRITE_N_I(gw_n),
    .BYTE_WRITE_GATE_N_I(gate_n), .BYTE_LANE_WRITE_N_I(lane_n), .OUT_ENABLE_N_I(oe_n),
    .BURST_ORDER_SELECT_I(ord), .SNOOZE_PIN_I(snz), .DQ_I(d), .DQ_O(dq), .DQ_OE_N_O(dq_oe_n),
    .SNOOZE_ACTIVE_O(snz_act));
  ////////////////////////////////////////////////////////////
  task automatic chk_d(input string n, input logic [17:0] e, input logic [17:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk_d
  task automatic chk_f(input string n, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s exp %b got %b", n, e, g);
    end
  endtask : chk_f
  task automatic wrap_up();
    if (fail_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////
  // read burst in the fixed group; load has lanes, writes and step low
  task automatic rd_burst(input logic [1:0] lo, input logic lin, input int hold);
    logic [1:0] cur;
    logic [1:0] idx;
    cur = 2'h0;
    u_pbs_host.load(BASE | 19'(lo), 3'h2, 1'b1, 4'h0, 18'h0);
    for (int k = 0; k < 5; k++) begin
      idx = lin ? lo + cur : lo ^ cur;
      if (k != hold) cur = cur + 2'h1;
      u_pbs_host.step(k == hold, 1'b1, 18'h0);
      chk_d("read data", grp[idx], dq);
      chk_f("drive enable", 1'b0, dq_oe_n);
    end
    u_pbs_host.idle();
  endtask : rd_burst
  task automatic t_burst();
    for (int k = 0; k < 4; k++) begin
      grp[2'h1 ^ k[1:0]] = 18'h1a5a0 + 18'(k);
    end
    u_pbs_host.load(BASE | 19'h1, 3'h2, 1'b0, 4'h7, grp[1]);
    for (int k = 1; k < 4; k++) begin
      u_pbs_host.step(1'b0, 1'b0, grp[2'h1 ^ k[1:0]]);
    end
    u_pbs_host.idle();
    rd_burst(2'h1, 1'b0, 9);
  endtask : t_burst
  task automatic t_linear();
    u_pbs_host.pins(1'b0, 1'b0);
    rd_burst(2'h3, 1'b1, 2);
    u_pbs_host.pins(1'b0, 1'b1);
  endtask : t_linear
  task automatic t_bytes();
    grp[0] = {grp[0][17:9], 9'h1ff};
    grp[3] = {9'h0aa, grp[3][8:0]};
    grp[1] = 18'h2b2b2;
    u_pbs_host.load(BASE, 3'h2, 1'b0, 4'ha, 18'h3ffff);
    u_pbs_host.load(BASE | 19'h3, 3'h2, 1'b0, 4'h9, 18'h15400);
    u_pbs_host.load(BASE | 19'h2, 3'h2, 1'b0, 4'hc, 18'h0);
    chk_f("drive enable", 1'b1, dq_oe_n);
    u_pbs_host.load(BASE | 19'h2, 3'h2, 1'b0, 4'hb, 18'h0);
    u_pbs_host.load(BASE | 19'h1, 3'h2, 1'b0, 4'h8, grp[1]);
    u_pbs_host.idle();
    rd_burst(2'h0, 1'b0, 9);
  endtask : t_bytes
  task automatic t_desel();
    logic [3:0] sel [4] = '{4'h0, 4'hb, 4'he, 4'h6};
    foreach (sel[i]) begin
      u_pbs_host.load(BASE, sel[i][2:0], sel[i][3], 4'hf, 18'h0);
      u_pbs_host.idle();
      chk_f("drive enable", 1'b1, dq_oe_n);
    end
  endtask : t_desel
  task automatic t_oe();
    u_pbs_host.pins(1'b1, 1'b1);
    u_pbs_host.load(BASE, 3'h2, 1'b1, 4'hf, 18'h0);
    u_pbs_host.idle();
    chk_f("drive enable", 1'b1, dq_oe_n);
    u_pbs_host.pins(1'b0, 1'b1);
    chk_f("drive enable", 1'b0, dq_oe_n);
  endtask : t_oe
  task automatic t_snooze();
    u_pbs_host.snooze(1'b1);
    chk_f("snooze state", 1'b1, snz_act);
    u_pbs_host.load(BASE, 3'h2, 1'b0, 4'h7, 18'h0);
    u_pbs_host.load(BASE, 3'h2, 1'b1, 4'hf, 18'h0);
    u_pbs_host.idle();
    chk_f("drive enable", 1'b1, dq_oe_n);
    u_pbs_host.snooze(1'b0);
    chk_f("snooze state", 1'b0, snz_act);
    rd_burst(2'h2, 1'b0, 9);
  endtask : t_snooze
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    chk_f("drive enable", 1'b1, dq_oe_n);
    chk_f("snooze state", 1'b0, snz_act);
    u_pbs_host.pins(1'b0, 1'b1);
    t_burst();
    t_linear();
    t_bytes();
    t_desel();
    t_oe();
    t_snooze();
    wrap_up();
  end
  initial begin
    #20us;
    fail_count++;
    wrap_up();
  end
endmodule : testbench
